// [design/usc_core.sv]
// universal serial shift core: shift data, counter, flags, capture buffer, avalon-mm slave
// Notes on behaviour
// - two-wire: stop condition sets stop flag; write one clears; never interrupts
// - collision bit reads one when data bit 7 differs from data pin level
// - status low nibble shows live counter; software may read or overwrite it
// - counter steps once per strobe or timer match, and on both edges of an external clock
// - external source with strobe select set: each toggle write clocks counter
// - counter still takes external clock when wire mode is none
// - shift register still uses data and clock pins when wire mode is none
// - each selected clock shifts data register one place toward msb
// - software write in same cycle as a shift clock wins; shift skipped
// - data output pin driven from msb through output latch, per wire mode
// - latch open first half of external clock cycle; always open internally
// - new msb written while latch open changes output at once
// - shift data reaches the pin only while its direction bit is one
// - completed transfer copies data register into capture buffer
// - counter wrap 15 to 0 sets wrap flag; write one clears; releases hold
// - start flag: start condition in two-wire, any clock edge otherwise; w1c
// - select 00 strobe, 01 timer match, 10/11 external rising/falling edge
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module usc_core
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// avalon-mm slave
	input usc_pkg::usc_bus_req_t bus_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	// timer compare match, same clock domain
	input wire logic timer_match_i,
	// serial pins
	input wire logic serial_in_pin_i,
	input wire logic serial_clock_pin_i,
	output usc_pkg::usc_pin_drive_t pins_o,
	// interrupt
	output logic irq_o
);
	import usc_pkg::*;

	// ========================================================
	// pin synchronisers
	logic scl_meta_reg;
	logic scl_sync_reg;
	logic scl_prev_reg;
	logic sda_meta_reg;
	logic sda_sync_reg;
	logic sda_prev_reg;

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			scl_meta_reg <= 1'b0;
			scl_sync_reg <= 1'b0;
			scl_prev_reg <= 1'b0;
			sda_meta_reg <= 1'b0;
			sda_sync_reg <= 1'b0;
			sda_prev_reg <= 1'b0;
		end
		else
		begin
			scl_meta_reg <= serial_clock_pin_i;
			scl_sync_reg <= scl_meta_reg;
			scl_prev_reg <= scl_sync_reg;
			sda_meta_reg <= serial_in_pin_i;
			sda_sync_reg <= sda_meta_reg;
			sda_prev_reg <= sda_sync_reg;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	assign scl_rise = scl_sync_reg & ~scl_prev_reg;
	assign scl_fall = ~scl_sync_reg & scl_prev_reg;
	// data edge while clock stays high
	assign start_cond = sda_prev_reg & ~sda_sync_reg & scl_sync_reg & scl_prev_reg;
	assign stop_cond = ~sda_prev_reg & sda_sync_reg & scl_sync_reg & scl_prev_reg;

	// ========================================================
	// bus slave: one wait cycle, then the access completes
	function automatic logic usc_hit(input logic [4:0] addr, input logic [4:0] off);
		usc_hit = (addr == off);
	endfunction

	logic wr_fire;
	logic wr_lane;
	logic [7:0] wd;
	assign wr_fire = bus_i.write & ~waitrequest_o;
	assign wr_lane = wr_fire & bus_i.byteenable[0];
	assign wd = bus_i.writedata[7:0];

	logic wr_ctrl;
	logic wr_status;
	logic wr_data;
	logic wr_port;
	logic wr_mask;
	assign wr_ctrl = wr_lane & usc_hit(bus_i.address, USC_CTRL_OFF);
	assign wr_status = wr_lane & usc_hit(bus_i.address, USC_STATUS_OFF);
	assign wr_data = wr_lane & usc_hit(bus_i.address, USC_DATA_OFF);
	assign wr_port = wr_lane & usc_hit(bus_i.address, USC_PORT_OFF);
	assign wr_mask = wr_lane & usc_hit(bus_i.address, USC_MASK_OFF);

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			waitrequest_o <= 1'b1;
		else if ((bus_i.read | bus_i.write) & waitrequest_o)
			waitrequest_o <= 1'b0;
		else
			waitrequest_o <= 1'b1;
	end

	// ========================================================
	// control, port and mask registers
	usc_wire_mode_t wire_mode_select_reg;
	usc_clock_sel_t clock_source_select_reg;
	logic count_by_toggle_reg;
	logic [3:0] port_reg;
	logic [1:0] irq_mask_reg;

	logic strobe_wr;
	logic toggle_wr;
	assign strobe_wr = wr_ctrl & wd[USC_CTRL_STROBE_BIT];
	assign toggle_wr = wr_ctrl & wd[USC_CTRL_TOGGLE_BIT];

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			wire_mode_select_reg <= USC_WM_NONE;
			clock_source_select_reg <= USC_CS_SOFT;
			count_by_toggle_reg <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			wire_mode_select_reg <= usc_wire_mode_t'(wd[USC_CTRL_WM_LSB +: 2]);
			clock_source_select_reg <= usc_clock_sel_t'(wd[USC_CTRL_CS_LSB +: 2]);
			// strobe bit doubles as counter source select for external clocking
			count_by_toggle_reg <= wd[USC_CTRL_STROBE_BIT];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			port_reg <= USC_CNT_RST;
		else if (wr_port)
			port_reg <= wd[3:0];
		else if (toggle_wr)
			port_reg[USC_PORT_CVAL_BIT] <= ~port_reg[USC_PORT_CVAL_BIT];
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			irq_mask_reg <= 2'h0;
		else if (wr_mask)
			irq_mask_reg <= wd[USC_ST_WRAP_BIT +: 2];
	end

	// ========================================================
	// clock event selection
	logic shift_evt;
	logic count_evt;

	always_comb
	begin
		shift_evt = 1'b0;
		count_evt = 1'b0;
		case (clock_source_select_reg)
			USC_CS_SOFT:
			begin
				shift_evt = strobe_wr;
				count_evt = strobe_wr;
			end
			USC_CS_TIMER:
			begin
				shift_evt = timer_match_i;
				count_evt = timer_match_i;
			end
			USC_CS_EXT_POS:
			begin
				// pin edges count in every wire mode, none included
				shift_evt = scl_rise;
				count_evt = count_by_toggle_reg ? toggle_wr : (scl_rise | scl_fall);
			end
			default:
			begin
				shift_evt = scl_fall;
				count_evt = count_by_toggle_reg ? toggle_wr : (scl_rise | scl_fall);
			end
		endcase
	end

	// ========================================================
	// shift data register and capture buffer
	logic [7:0] shift_data_reg;
	logic [7:0] shift_data_next;
	logic [7:0] capture_buffer_reg;
	logic [3:0] transfer_count_reg;
	logic wrap_evt;

	always_comb
	begin
		shift_data_next = shift_data_reg;
		if (wr_data)
			shift_data_next = wd;
		else if (shift_evt)
			shift_data_next = {shift_data_reg[6:0], sda_sync_reg};
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			shift_data_reg <= USC_BYTE_RST;
		else
			shift_data_reg <= shift_data_next;
	end

	assign wrap_evt = count_evt & ~wr_status & (transfer_count_reg == USC_CNT_LAST);

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			capture_buffer_reg <= USC_BYTE_RST;
		else if (wrap_evt)
			capture_buffer_reg <= shift_data_next;
	end

	// ========================================================
	// transfer counter
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			transfer_count_reg <= USC_CNT_RST;
		else if (wr_status)
			transfer_count_reg <= wd[USC_ST_CNT_LSB +: 4];
		else if (count_evt)
			transfer_count_reg <= transfer_count_reg + USC_CNT_STEP;
	end

	// ========================================================
	// status flags: a set in the clearing cycle wins, except wrap, which any status write suppresses
	logic start_seen_flag_reg;
	logic count_wrap_flag_reg;
	logic stop_seen_flag_reg;
	logic output_collision_bit_reg;
	logic two_wire;
	logic start_set;
	assign two_wire = wire_mode_select_reg[1];
	assign start_set = two_wire ? start_cond : (scl_rise | scl_fall);

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			start_seen_flag_reg <= 1'b0;
			count_wrap_flag_reg <= 1'b0;
			stop_seen_flag_reg <= 1'b0;
		end
		else
		begin
			start_seen_flag_reg <= start_set |
				(start_seen_flag_reg & ~(wr_status & wd[USC_ST_START_BIT]));
			count_wrap_flag_reg <= wrap_evt |
				(count_wrap_flag_reg & ~(wr_status & wd[USC_ST_WRAP_BIT]));
			stop_seen_flag_reg <= (two_wire & stop_cond) |
				(stop_seen_flag_reg & ~(wr_status & wd[USC_ST_STOP_BIT]));
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			output_collision_bit_reg <= 1'b0;
		else
			output_collision_bit_reg <= shift_data_reg[7] ^ sda_sync_reg;
	end

	// stop flag stays out of the interrupt on purpose
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			irq_o <= 1'b0;
		else
			irq_o <= |({start_seen_flag_reg, count_wrap_flag_reg} & irq_mask_reg);
	end

	// ========================================================
	// output latch and pin drive
	logic latch_open;
	logic out_latch_reg;
	logic out_latch_next;
	logic clk_hold;
	usc_pin_drive_t pins_next;

	// next clock port value, so a toggle or port write shows on the same edge
	function automatic logic pins_next_clk_val(input logic [3:0] p, input logic tg,
		input logic wp, input logic [7:0] d);
		if (wp)
			pins_next_clk_val = d[USC_PORT_CVAL_BIT];
		else
			pins_next_clk_val = p[USC_PORT_CVAL_BIT] ^ tg;
	endfunction

	// external clock: open in the half opposite to the sampling edge
	assign latch_open = ~clock_source_select_reg[1] |
		(scl_sync_reg == clock_source_select_reg[0]);
	// feed from the next value so a written msb shows on the same edge
	assign out_latch_next = latch_open ? shift_data_next[7] : out_latch_reg;

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			out_latch_reg <= 1'b0;
		else
			out_latch_reg <= out_latch_next;
	end

	assign clk_hold = (start_seen_flag_reg & ~(wr_status & wd[USC_ST_START_BIT])) |
		((wire_mode_select_reg == USC_WM_TWO_HOLD) & count_wrap_flag_reg &
		~(wr_status & wd[USC_ST_WRAP_BIT]));

	always_comb
	begin
		pins_next.data_out = port_reg[USC_PORT_DVAL_BIT];
		pins_next.data_oe = port_reg[USC_PORT_DDIR_BIT];
		pins_next.clock_out = port_reg[USC_PORT_CVAL_BIT];
		pins_next.clock_oe = port_reg[USC_PORT_CDIR_BIT];
		if (wire_mode_select_reg == USC_WM_THREE)
			pins_next.data_out = out_latch_next;
		else if (two_wire)
		begin
			// open drain: enable means pull low
			pins_next.data_out = 1'b0;
			pins_next.data_oe = port_reg[USC_PORT_DDIR_BIT] &
				(~out_latch_next | ~port_reg[USC_PORT_DVAL_BIT]);
			pins_next.clock_out = 1'b0;
			pins_next.clock_oe = port_reg[USC_PORT_CDIR_BIT] &
				(~pins_next_clk_val(port_reg, toggle_wr, wr_port, wd) | clk_hold);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			pins_o <= '0;
		else
			pins_o <= pins_next;
	end

	// ========================================================
	// read data, set up in the wait cycle
	logic [7:0] status_view;
	assign status_view = {start_seen_flag_reg, count_wrap_flag_reg, stop_seen_flag_reg,
		output_collision_bit_reg, transfer_count_reg};

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			readdata_o <= USC_WORD_ZERO;
		else if (bus_i.read & waitrequest_o)
		begin
			// strobe and toggle bits always read as zero
			if (usc_hit(bus_i.address, USC_CTRL_OFF))
				readdata_o <= {24'h0, 2'h0, wire_mode_select_reg, clock_source_select_reg, 2'h0};
			else if (usc_hit(bus_i.address, USC_STATUS_OFF))
				readdata_o <= {24'h0, status_view};
			else if (usc_hit(bus_i.address, USC_DATA_OFF))
				readdata_o <= {24'h0, shift_data_reg};
			else if (usc_hit(bus_i.address, USC_BUFFER_OFF))
				readdata_o <= {24'h0, capture_buffer_reg};
			else if (usc_hit(bus_i.address, USC_PORT_OFF))
				readdata_o <= {28'h0, port_reg};
			else if (usc_hit(bus_i.address, USC_MASK_OFF))
				readdata_o <= {24'h0, irq_mask_reg, 6'h00};
			else
				readdata_o <= USC_WORD_ZERO;
		end
	end

endmodule // usc_core

// [design/usc_pkg.sv]
// package of constants and types for the universal serial shift core
package usc_pkg;

	// ========================================================
	// register map (byte addresses, one 32-bit word each)
	localparam logic [4:0] USC_CTRL_OFF = 5'h00;
	localparam logic [4:0] USC_STATUS_OFF = 5'h04;
	localparam logic [4:0] USC_DATA_OFF = 5'h08;
	localparam logic [4:0] USC_BUFFER_OFF = 5'h0c;
	localparam logic [4:0] USC_PORT_OFF = 5'h10;
	localparam logic [4:0] USC_MASK_OFF = 5'h14;

	// ========================================================
	// control word fields
	localparam int USC_CTRL_TOGGLE_BIT = 0;
	localparam int USC_CTRL_STROBE_BIT = 1;
	localparam int USC_CTRL_CS_LSB = 2;
	localparam int USC_CTRL_WM_LSB = 4;

	// status word fields
	localparam int USC_ST_START_BIT = 7;
	localparam int USC_ST_WRAP_BIT = 6;
	localparam int USC_ST_STOP_BIT = 5;
	localparam int USC_ST_COLL_BIT = 4;
	localparam int USC_ST_CNT_LSB = 0;

	// port word fields
	localparam int USC_PORT_DDIR_BIT = 0;
	localparam int USC_PORT_CDIR_BIT = 1;
	localparam int USC_PORT_DVAL_BIT = 2;
	localparam int USC_PORT_CVAL_BIT = 3;

	// ========================================================
	// reset values and counts
	localparam logic [7:0] USC_BYTE_RST = 8'h00;
	localparam logic [3:0] USC_CNT_RST = 4'h0;
	localparam logic [3:0] USC_CNT_LAST = 4'hf;
	localparam logic [3:0] USC_CNT_STEP = 4'h1;
	localparam logic [31:0] USC_WORD_ZERO = 32'h0000_0000;

	// ========================================================
	// modes
	typedef enum logic [1:0] {
		USC_WM_NONE,
		USC_WM_THREE,
		USC_WM_TWO,
		USC_WM_TWO_HOLD
	} usc_wire_mode_t;

	typedef enum logic [1:0] {
		USC_CS_SOFT,
		USC_CS_TIMER,
		USC_CS_EXT_POS,
		USC_CS_EXT_NEG
	} usc_clock_sel_t;

	// ========================================================
	// avalon-mm request from the master
	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} usc_bus_req_t;

	// pin drive towards the pads
	typedef struct packed {
		logic data_out;
		logic data_oe;
		logic clock_out;
		logic clock_oe;
	} usc_pin_drive_t;

endpackage

// [sim/usc_core_properties.sv]
// checker of bus handshake, read data and interrupt release of the shift core
`timescale 1ns/10ps
module usc_core_properties
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// watched ports
	input usc_pkg::usc_bus_req_t bus_i,
	input wire logic [31:0] readdata_o,
	input wire logic waitrequest_o,
	input wire logic irq_o
);
	import usc_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// ========
	// sequences
	sequence s_taken;
		(bus_i.read || bus_i.write) && waitrequest_o;
	endsequence
	sequence s_read_ack(logic hit);
		bus_i.read && hit && waitrequest_o ##1 !waitrequest_o;
	endsequence
	// ========
	// properties
	a_wait_answer: assert property (s_taken |=> !waitrequest_o)
		else $error("request not answered next cycle");
	a_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
		else $error("waitrequest low longer than one cycle");
	a_wait_idle: assert property (!(bus_i.read || bus_i.write) && waitrequest_o |=> waitrequest_o)
		else $error("answer without request");
	a_read_hold: assert property (!bus_i.read |=> $stable(readdata_o))
		else $error("read data moved without a read");
	a_upper_zero: assert property (!waitrequest_o |-> readdata_o[31:8] == 24'h0)
		else $error("read data upper lanes not zero");
	a_unmapped_zero: assert property (s_read_ack(bus_i.address > USC_MASK_OFF) |-> readdata_o == USC_WORD_ZERO)
		else $error("unmapped read not zero");
	a_strobe_reads_zero: assert property (s_read_ack(bus_i.address == USC_CTRL_OFF) |-> readdata_o[1:0] == 2'h0)
		else $error("strobe or toggle bit reads one");
	a_irq_clear: assert property ($fell(irq_o) |-> $past(bus_i.write) || $past(bus_i.write, 2) || $past(bus_i.write, 3))
		else $error("interrupt dropped without a write");
endmodule // usc_core_properties

// [sim/usc_core_tb.sv]
// self-checking bench of the universal serial shift core
`timescale 1ns/10ps
module usc_core_tb;
	import usc_pkg::*;
	// ========
	// signals
	logic clk_i, rst_b_i, wait_r, tmr, go, sck, sd, busy, irq;
	usc_bus_req_t req;
	logic [31:0] rdata;
	usc_pin_drive_t pins;
	logic [7:0] tx, q;
	logic [15:0] rnd;
	int n_errors, checked, m_data, m_cnt, m_flags, m_buf, m_mask;
	logic [4:0] offs [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18};
	logic [7:0] wv [4] = '{8'h40, 8'h40, 8'h80, 8'h80};
	usc_core usc_core_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(req), .readdata_o(rdata),
		.waitrequest_o(wait_r), .timer_match_i(tmr), .serial_in_pin_i(sd),
		.serial_clock_pin_i(sck), .pins_o(pins), .irq_o(irq));
	usc_link_master usc_link_master_i (.clk_i(clk_i), .go_i(go), .byte_i(tx), .sck_o(sck),
		.sd_o(sd), .busy_o(busy));
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// ========
	// tasks
	task automatic wrap_up();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// tm raises a timer match in the cycle the access takes effect
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic tm);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= '{read: !wr, write: wr, address: a, byteenable: 4'hf, writedata: {24'h0, d}};
		do
		begin
			@(posedge clk_i);
			n++;
			if (n == 1)
				tmr <= tm;
		end
		while (wait_r !== 1'b0 && n < 50);
		q = rdata[7:0];
		req <= '0;
		tmr <= 1'b0;
		if (wait_r !== 1'b0)
		begin
			n_errors++;
			wrap_up();
		end
	endtask
	task automatic rd_chk(input string nm, input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 1'b0);
		chk(nm, e, q);
	endtask
	task automatic tick(input int sh);
		if (sh)
			m_data = ((m_data << 1) | sd) & 255;
		if (m_cnt == 15)
		begin
			m_flags |= 64;
			m_buf = m_data;
		end
		m_cnt = (m_cnt + 1) & 15;
	endtask
	function automatic logic [7:0] st();
		return 8'(m_flags | ((((m_data >> 7) & 1) ^ sd) << 4) | m_cnt);
	endfunction
	task automatic irq_chk();
		repeat (3) @(posedge clk_i);
		chk("irq", {7'h0, (m_flags & m_mask) != 0}, {7'h0, irq});
	endtask
	// ========
	// sequence
	initial
	begin
		rst_b_i = 1'b0;
		req = '0;
		tmr = 1'b0;
		go = 1'b0;
		tx = 8'h00;
		rnd = 16'hbe54;
		{n_errors, checked, m_data, m_cnt, m_flags, m_buf, m_mask} = '0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		foreach (offs[i]) rd_chk("reset value", offs[i], 8'h00);
		bus(1'b1, USC_STATUS_OFF, 8'h0e, 1'b0);
		m_cnt = 14;
		rd_chk("counter", USC_STATUS_OFF, st());
		rnd = lfsr(rnd);
		bus(1'b1, USC_DATA_OFF, rnd[7:0], 1'b0);
		m_data = rnd[7:0];
		repeat (2)
		begin
			bus(1'b1, USC_CTRL_OFF, 8'h02, 1'b0);
			tick(1);
		end
		rd_chk("shift data", USC_DATA_OFF, 8'(m_data));
		rd_chk("status", USC_STATUS_OFF, st());
		rd_chk("capture", USC_BUFFER_OFF, 8'(m_buf));
		bus(1'b1, USC_STATUS_OFF, 8'h40, 1'b0);
		m_flags = 0;
		bus(1'b1, USC_CTRL_OFF, 8'h04, 1'b0);
		rnd = lfsr(rnd);
		bus(1'b1, USC_DATA_OFF, rnd[7:0], 1'b1);
		m_data = rnd[7:0];
		tick(0);
		rd_chk("write wins", USC_DATA_OFF, 8'(m_data));
		bus(1'b0, USC_MASK_OFF, 8'h00, 1'b1);
		tick(1);
		rd_chk("timer shift", USC_DATA_OFF, 8'(m_data));
		rd_chk("timer count", USC_STATUS_OFF, st());
		bus(1'b1, USC_CTRL_OFF, 8'h10, 1'b0);
		bus(1'b1, USC_PORT_OFF, 8'h01, 1'b0);
		for (int i = 0; i < 2; i++)
		begin
			bus(1'b1, USC_DATA_OFF, i ? 8'h00 : 8'h80, 1'b0);
			@(posedge clk_i);
			chk("data pin", i ? 8'h00 : 8'h01, {7'h0, pins.data_out});
			chk("data enable", 8'h01, {7'h0, pins.data_oe});
		end
		bus(1'b1, USC_PORT_OFF, 8'h00, 1'b0);
		// port bits reach the pins one edge after the port register
		repeat (2) @(posedge clk_i);
		chk("data enable", 8'h00, {7'h0, pins.data_oe});
		bus(1'b1, USC_MASK_OFF, 8'hc0, 1'b0);
		m_mask = 8'hc0;
		for (int cs = 2; cs < 4; cs++)
		begin
			bus(1'b1, USC_CTRL_OFF, 8'(cs << 2), 1'b0);
			bus(1'b1, USC_STATUS_OFF, 8'he0, 1'b0);
			rnd = lfsr(rnd);
			tx <= rnd[7:0];
			go <= 1'b1;
			@(posedge clk_i);
			go <= 1'b0;
			for (int k = 0; k < 200 && (busy || k < 2); k++)
				@(posedge clk_i);
			if (busy)
			begin
				n_errors++;
				wrap_up();
			end
			repeat (4) @(posedge clk_i);
			m_data = rnd[7:0];
			m_buf = rnd[7:0];
			m_cnt = 0;
			m_flags = 8'hc0;
			rd_chk("link data", USC_DATA_OFF, 8'(m_data));
			rd_chk("link status", USC_STATUS_OFF, st());
			rd_chk("link capture", USC_BUFFER_OFF, 8'(m_buf));
		end
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, i[0] ? USC_STATUS_OFF : USC_MASK_OFF, wv[i], 1'b0);
			if (i[0])
				m_flags &= ~int'(wv[i]);
			else
				m_mask = wv[i];
			irq_chk();
		end
		bus(1'b1, USC_CTRL_OFF, 8'h0a, 1'b0);
		bus(1'b1, USC_CTRL_OFF, 8'h0b, 1'b0);
		tick(0);
		rd_chk("toggle count", USC_STATUS_OFF, st());
		chk("clock pin", 8'h02, {6'h0, pins.clock_out, pins.clock_oe});
		// two-wire: data line pulled low while the latched msb or the port data value bit is zero
		bus(1'b1, USC_PORT_OFF, 8'h05, 1'b0);
		bus(1'b1, USC_CTRL_OFF, 8'h20, 1'b0);
		for (int i = 0; i < 2; i++)
		begin
			bus(1'b1, USC_DATA_OFF, i ? 8'h80 : 8'h00, 1'b0);
			@(posedge clk_i);
			chk("two-wire pull", i ? 8'h00 : 8'h01, {6'h0, pins.data_out, pins.data_oe});
		end
		wrap_up();
	end
endmodule // usc_core_tb
bind usc_core usc_core_properties usc_core_properties_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.bus_i(bus_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .irq_o(irq_o));

// [sim/usc_link_master.sv]
// serial master model driving the link clock and data pins for one byte
`timescale 1ns/10ps
module usc_link_master
(
	// clock and request
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [7:0] byte_i,
	// link pins and busy flag
	output logic sck_o,
	output logic sd_o,
	output logic busy_o
);
	logic [7:0] sh;
	logic [6:0] ph;
	initial
	begin
		sck_o = 1'b0;
		sd_o = 1'b0;
		busy_o = 1'b0;
	end
	// clock idles low; data moves mid low phase, clear of both edges
	always @(posedge clk_i)
	begin
		if (!busy_o)
		begin
			busy_o <= go_i;
			sh <= byte_i;
			ph <= 7'h00;
		end
		else
		begin
			ph <= ph + 7'h01;
			busy_o <= ph != 7'h47;
			sck_o <= ph[2] && ph < 7'h40;
			if (ph[2:0] == 3'h2 && ph < 7'h40)
			begin
				sd_o <= sh[7];
				sh <= sh << 1;
			end
			// a released line must not keep showing the last bit
			if (ph == 7'h46)
				sd_o <= ~sd_o;
		end
	end
endmodule // usc_link_master
